// *** rtl/oaq_pkg.sv ***
// Purpose: Shared constants, types and helpers of the overcurrent alert qualifier.
// Assumes: A 50 MHz clock; sense codes in steps of 0.1 mV.
// Notes: Register map, field positions, reset values and timing counts live here.
// How it works
// - A free-running 10 us comparison window timer runs with no external start, stop or view.
// - At each window end the averaged input is compared with the threshold, giving one verdict.
// - In the shortest setting one over-threshold verdict drives the alert low at once.
// - In the middle setting five consecutive over-threshold verdicts are needed for an alert.
// - A verdict below threshold before the count is reached clears the count with no alert.
// - In the longest setting ten consecutive over-threshold verdicts are needed for an alert.
// - The delay pin decodes floating as 10 us, ground as 50 us and supply as 100 us.
// - The middle and longest settings add 40 us and 90 us of latency over the shortest.
// - As the window runs free, alert latency varies by up to one window after the crossing.
// - The hysteresis pin decodes floating as 2 mV, ground as 4 mV and supply as 8 mV.
// - The alert output is active low and otherwise released to its high level.
// - With latch select low the alert is released after one window below threshold.
// - With latch select high the alert holds until latch select is low 20 us and input is low.
// - Disabling the device clears the consecutive count, which restarts from zero on enable.
package oaq_pkg;

  localparam int CLK_NS = 20;
  localparam int WINDOW_NS = 10000;
  localparam int WIN_CYC = WINDOW_NS / CLK_NS;
  localparam int LATCH_CLR_NS = 20000;
  localparam int LATCH_CLR_CYC = (LATCH_CLR_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [8:0] WIN_LAST = 9'(WIN_CYC - 1);
  localparam logic [10:0] LATCH_CLR_LAST = 11'(LATCH_CLR_CYC - 1);

  localparam logic [3:0] CNT_SHORT = 4'h1;
  localparam logic [3:0] CNT_MID = 4'h5;
  localparam logic [3:0] CNT_LONG = 4'hA;

  localparam logic [15:0] HYS_SMALL = 16'h0014;
  localparam logic [15:0] HYS_MID = 16'h0028;
  localparam logic [15:0] HYS_LARGE = 16'h0050;

  localparam logic [7:0] ADDR_STATE = 8'h00;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  localparam logic [15:0] LIMIT_RST = 16'h03E8;
  localparam logic [1:0] MASK_RST = 2'h0;

  localparam int IRQ_ALERT_SET = 0;
  localparam int IRQ_ALERT_CLR = 1;

  localparam int ST_ALERT = 0;
  localparam int ST_HELD = 1;
  localparam int ST_OVER = 2;
  localparam int ST_ENABLE = 3;
  localparam int ST_LATCH = 4;
  localparam int ST_PIN = 5;
  localparam int ST_DLY = 8;
  localparam int ST_HYS = 10;
  localparam int ST_CNT = 12;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    OAQ_SEL_FLOAT = 2'h0,
    OAQ_SEL_GND = 2'h1,
    OAQ_SEL_SUPPLY = 2'h2
  } oaq_sel_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } oaq_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } oaq_axi_rsp_t;

  typedef struct packed {
    logic dly_gnd;
    logic dly_supply;
    logic hys_gnd;
    logic hys_supply;
    logic latch_sel;
    logic enable;
    logic alert_pin;
  } oaq_pins_t;

  // A pin sensed at both rails is treated as floating.
  function automatic oaq_sel_t sel_decode(input logic gnd, input logic supply);
    if (supply && !gnd) begin
      return OAQ_SEL_SUPPLY;
    end else if (gnd && !supply) begin
      return OAQ_SEL_GND;
    end
    return OAQ_SEL_FLOAT;
  endfunction

  function automatic logic reg_known(input logic [7:0] addr);
    return addr == ADDR_STATE || addr == ADDR_LIMIT || addr == ADDR_IRQ_STAT ||
           addr == ADDR_IRQ_MASK;
  endfunction

endpackage

// *** rtl/oaq_sync3.sv ***
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to clk.
// Notes: The output changes once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module oaq_sync3 #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output var logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] f1;
    logic [W-1:0] f2;
    logic [W-1:0] f3;
    logic [W-1:0] qv;
  } oaq_sync_t;

  oaq_sync_t s_q;
  oaq_sync_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.f1 = d;
    s_d.f2 = s_q.f1;
    s_d.f3 = s_q.f2;
    s_d.qv = (s_q.f2 & s_q.f3) | (s_q.qv & (s_q.f2 ^ s_q.f3));
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.qv;

endmodule
`default_nettype wire

// *** rtl/oaq_top.sv ***
// Purpose: Qualifies per-window overcurrent verdicts into an active-low open-drain alert.
// Assumes: sense_avg is the window-averaged input from same-clock logic, 0.1 mV per step.
// Notes: Registers on AXI4-Lite; one write and one read under way at a time.
`timescale 1ns/1ps
`default_nettype none
module oaq_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire oaq_pkg::oaq_axi_req_t axi_req,
  output var oaq_pkg::oaq_axi_rsp_t axi_rsp,
  input wire oaq_pkg::oaq_pins_t pins,
  input wire logic [15:0] sense_avg,
  output var logic alert_out,
  output var logic alert_oe,
  output var logic irq
);

  typedef struct packed {
    logic [8:0] win;
    logic [3:0] cnt;
    logic over;
    logic alert;
    logic held;
    logic [10:0] lat_cnt;
    logic [1:0] irq_st;
    logic [1:0] irq_mask;
    logic [15:0] limit;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } oaq_state_t;

  oaq_state_t st_q;
  oaq_state_t st_d;
  oaq_pkg::oaq_pins_t pin_s;
  oaq_pkg::oaq_sel_t dly_sel;
  oaq_pkg::oaq_sel_t hys_sel;
  logic [3:0] need_cnt;
  logic [15:0] hys_amt;
  logic [15:0] low_limit;
  logic win_end;
  logic verdict;
  logic [31:0] state_word;

  oaq_sync3 #(
    .W($bits(oaq_pkg::oaq_pins_t))
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .d(pins),
    .q(pin_s)
  );

  assign dly_sel = oaq_pkg::sel_decode(pin_s.dly_gnd, pin_s.dly_supply);
  assign hys_sel = oaq_pkg::sel_decode(pin_s.hys_gnd, pin_s.hys_supply);

  always_comb begin
    unique case (dly_sel)
      oaq_pkg::OAQ_SEL_GND: need_cnt = oaq_pkg::CNT_MID;
      oaq_pkg::OAQ_SEL_SUPPLY: need_cnt = oaq_pkg::CNT_LONG;
      default: need_cnt = oaq_pkg::CNT_SHORT;
    endcase
  end

  always_comb begin
    unique case (hys_sel)
      oaq_pkg::OAQ_SEL_GND: hys_amt = oaq_pkg::HYS_MID;
      oaq_pkg::OAQ_SEL_SUPPLY: hys_amt = oaq_pkg::HYS_LARGE;
      default: hys_amt = oaq_pkg::HYS_SMALL;
    endcase
  end

  // The release level never wraps below zero for a small threshold.
  assign low_limit = (st_q.limit > hys_amt) ? 16'(st_q.limit - hys_amt) : 16'h0000;

  assign win_end = st_q.win == oaq_pkg::WIN_LAST;
  // Once over, the window stays over until the input drops under the lower level.
  assign verdict = st_q.over ? (sense_avg >= low_limit) : (sense_avg > st_q.limit);

  always_comb begin
    state_word = 32'h0000_0000;
    state_word[oaq_pkg::ST_ALERT] = st_q.alert;
    state_word[oaq_pkg::ST_HELD] = st_q.held;
    state_word[oaq_pkg::ST_OVER] = st_q.over;
    state_word[oaq_pkg::ST_ENABLE] = pin_s.enable;
    state_word[oaq_pkg::ST_LATCH] = pin_s.latch_sel;
    state_word[oaq_pkg::ST_PIN] = pin_s.alert_pin;
    state_word[oaq_pkg::ST_DLY +: 2] = dly_sel;
    state_word[oaq_pkg::ST_HYS +: 2] = hys_sel;
    state_word[oaq_pkg::ST_CNT +: 4] = st_q.cnt;
  end

  always_comb begin
    logic [1:0] irq_ev;
    logic [1:0] irq_clr;
    logic [3:0] cnt_inc;
    irq_ev = 2'h0;
    irq_clr = 2'h0;
    cnt_inc = 4'(st_q.cnt + 4'h1);
    st_d = st_q;

    // The window timer free-runs even while disabled.
    st_d.win = win_end ? 9'h000 : 9'(st_q.win + 9'h001);

    if (win_end) begin
      st_d.over = verdict;
      if (verdict) begin
        if (cnt_inc >= need_cnt) begin
          st_d.alert = 1'b1;
          st_d.cnt = need_cnt;
        end else begin
          st_d.cnt = cnt_inc;
        end
      end else begin
        st_d.cnt = 4'h0;
        if (!st_q.held) begin
          st_d.alert = 1'b0;
        end
      end
    end

    // Latch-low time counts up and saturates; latch high restarts it.
    if (pin_s.latch_sel) begin
      st_d.lat_cnt = 11'h000;
    end else if (st_q.lat_cnt != oaq_pkg::LATCH_CLR_LAST) begin
      st_d.lat_cnt = 11'(st_q.lat_cnt + 11'h001);
    end

    if (pin_s.latch_sel && st_d.alert) begin
      st_d.held = 1'b1;
    end else if (!pin_s.latch_sel && st_q.held &&
                 st_q.lat_cnt == oaq_pkg::LATCH_CLR_LAST && !st_d.over) begin
      st_d.held = 1'b0;
      st_d.alert = 1'b0;
    end

    if (!pin_s.enable) begin
      st_d.cnt = 4'h0;
      st_d.over = 1'b0;
      st_d.alert = 1'b0;
      st_d.held = 1'b0;
    end

    irq_ev[oaq_pkg::IRQ_ALERT_SET] = st_d.alert && !st_q.alert;
    irq_ev[oaq_pkg::IRQ_ALERT_CLR] = !st_d.alert && st_q.alert;

    if (axi_req.awvalid && axi_rsp.awready) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = axi_req.wdata;
      st_d.wstrb = axi_req.wstrb;
    end

    if (st_q.aw_got && st_q.w_got) begin
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = oaq_pkg::reg_known(st_q.awaddr) ? oaq_pkg::RESP_OKAY
                                                   : oaq_pkg::RESP_DECERR;
      if (st_q.awaddr == oaq_pkg::ADDR_LIMIT) begin
        if (st_q.wstrb[0]) begin
          st_d.limit[7:0] = st_q.wdata[7:0];
        end
        if (st_q.wstrb[1]) begin
          st_d.limit[15:8] = st_q.wdata[15:8];
        end
      end
      if (st_q.awaddr == oaq_pkg::ADDR_IRQ_MASK && st_q.wstrb[0]) begin
        st_d.irq_mask = st_q.wdata[1:0];
      end
      if (st_q.awaddr == oaq_pkg::ADDR_IRQ_STAT && st_q.wstrb[0]) begin
        irq_clr = st_q.wdata[1:0];
      end
    end else if (st_q.bvalid && axi_req.bready) begin
      st_d.bvalid = 1'b0;
    end

    // A new event in the clearing cycle survives the clear.
    st_d.irq_st = (st_q.irq_st & ~irq_clr) | irq_ev;

    if (axi_req.arvalid && axi_rsp.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = oaq_pkg::RESP_OKAY;
      unique case (axi_req.araddr)
        oaq_pkg::ADDR_STATE: st_d.rdata = state_word;
        oaq_pkg::ADDR_LIMIT: st_d.rdata = {16'h0000, st_q.limit};
        oaq_pkg::ADDR_IRQ_STAT: st_d.rdata = {30'h0000_0000, st_q.irq_st};
        oaq_pkg::ADDR_IRQ_MASK: st_d.rdata = {30'h0000_0000, st_q.irq_mask};
        default: begin
          st_d.rdata = 32'h0000_0000;
          st_d.rresp = oaq_pkg::RESP_DECERR;
        end
      endcase
    end else if (st_q.rvalid && axi_req.rready) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.limit <= oaq_pkg::LIMIT_RST;
      st_q.irq_mask <= oaq_pkg::MASK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  always_comb begin
    axi_rsp = '0;
    axi_rsp.awready = !st_q.aw_got && !st_q.bvalid;
    axi_rsp.wready = !st_q.w_got && !st_q.bvalid;
    axi_rsp.bvalid = st_q.bvalid;
    axi_rsp.bresp = st_q.bresp;
    axi_rsp.arready = !st_q.rvalid;
    axi_rsp.rvalid = st_q.rvalid;
    axi_rsp.rdata = st_q.rdata;
    axi_rsp.rresp = st_q.rresp;
  end

  // The pin is only ever pulled low; the enable carries the alert.
  assign alert_out = 1'b0;
  assign alert_oe = st_q.alert;
  assign irq = |(st_q.irq_st & st_q.irq_mask);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_window_end_over;
    win_end && pin_s.enable && verdict;
  endsequence

  sequence s_window_end_under;
    win_end && pin_s.enable && !verdict;
  endsequence

  sequence s_latch_low_wait;
    !pin_s.latch_sel && st_q.lat_cnt == oaq_pkg::LATCH_CLR_LAST;
  endsequence

  property p_window_period;
    win_end |=> (st_q.win == 9'h000) ##1 (st_q.win == 9'h001) ##1 !win_end [*8];
  endproperty
  a_window_period: assert property (p_window_period)
    else $error("window timer did not restart after its last count");

  property p_short_alert;
    s_window_end_over ##0 (dly_sel == oaq_pkg::OAQ_SEL_FLOAT) |=> alert_oe;
  endproperty
  a_short_alert: assert property (p_short_alert)
    else $error("single over verdict did not assert alert in short setting");

  property p_mid_count;
    $rose(alert_oe) && dly_sel == oaq_pkg::OAQ_SEL_GND && $stable(dly_sel)
      |-> $past(st_q.cnt) == 4'h4;
  endproperty
  a_mid_count: assert property (p_mid_count)
    else $error("middle setting alerted without five consecutive over windows");

  property p_under_clears;
    s_window_end_under |=> st_q.cnt == 4'h0;
  endproperty
  a_under_clears: assert property (p_under_clears)
    else $error("under verdict did not clear the consecutive count");

  property p_long_count;
    $rose(alert_oe) && dly_sel == oaq_pkg::OAQ_SEL_SUPPLY && $stable(dly_sel)
      |-> $past(st_q.cnt) == 4'h9;
  endproperty
  a_long_count: assert property (p_long_count)
    else $error("long setting alerted without ten consecutive over windows");

  property p_open_drain;
    alert_out == 1'b0 && alert_oe == st_q.alert;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("alert pin drives high or its enable diverges");

  property p_transparent_release;
    s_window_end_under ##0 !st_q.held |=> !alert_oe;
  endproperty
  a_transparent_release: assert property (p_transparent_release)
    else $error("alert not released after a window under threshold");

  property p_latch_hold;
    st_q.held && pin_s.latch_sel && pin_s.enable |=> alert_oe;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched alert released while latch select was high");

  property p_latch_clear;
    s_latch_low_wait ##0 st_q.held && !st_q.over && !win_end |=> !alert_oe;
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("latched alert not cleared after latch select held low");

  property p_disable_clears;
    !pin_s.enable |=> st_q.cnt == 4'h0 && !alert_oe;
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("disable did not clear the consecutive count");

  property p_hysteresis;
    win_end && st_q.over && pin_s.enable && sense_avg >= low_limit |=> st_q.over;
  endproperty
  a_hysteresis: assert property (p_hysteresis)
    else $error("over state dropped while input was inside the hysteresis band");

  property p_bresp_hold;
    st_q.bvalid && !axi_req.bready |=> st_q.bvalid && $stable(st_q.bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before bready");

  property p_rise_at_window_end;
    $rose(alert_oe) |-> $past(win_end);
  endproperty
  a_rise_at_window_end: assert property (p_rise_at_window_end)
    else $error("alert asserted away from a window end");

  property p_threshold_strict;
    win_end && pin_s.enable && !st_q.over && sense_avg <= st_q.limit |=> !st_q.over;
  endproperty
  a_threshold_strict: assert property (p_threshold_strict)
    else $error("window at or below threshold judged over");

  property p_latch_release_under;
    $fell(alert_oe) && $past(st_q.held) |-> !st_q.over;
  endproperty
  a_latch_release_under: assert property (p_latch_release_under)
    else $error("latched alert released while the input was still over");

  property p_alert_sets_status;
    $rose(alert_oe) |-> st_q.irq_st[oaq_pkg::IRQ_ALERT_SET];
  endproperty
  a_alert_sets_status: assert property (p_alert_sets_status)
    else $error("alert assertion did not set its status bit");

endmodule
`default_nettype wire

// *** dv/oaq_ctl_model.sv ***
// Purpose: System controller model that drives the strap pins, enable and latch select.
// Assumes: The alert wire has a pull-up, so it reads high unless the block pulls it low.
// Notes: The bench sets the commands; the latch low time is kept by the bench's sequence.
`timescale 1ns/1ps
`default_nettype none
module oaq_ctl_model (
  input wire logic en,
  input wire logic latch,
  input wire logic [1:0] dly,
  input wire logic [1:0] hysteresis_select,
  input wire logic alert_out,
  input wire logic alert_oe,
  output var oaq_pkg::oaq_pins_t pins
);
  // Code 1 ties a strap to ground, code 2 to supply, anything else leaves it floating.
  assign pins.dly_gnd = dly == 2'h1;
  assign pins.dly_supply = dly == 2'h2;
  assign pins.hys_gnd = hysteresis_select == 2'h1;
  assign pins.hys_supply = hysteresis_select == 2'h2;
  assign pins.latch_sel = latch;
  assign pins.enable = en;
  assign pins.alert_pin = alert_oe ? alert_out : 1'b1;
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench of the alert qualifier against a window-level model.
// Assumes: Checks are made mid-window, so sync latency of the pins never matters.
// Notes: The window phase is learnt from the first alert after reset.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  oaq_pkg::oaq_axi_req_t req = '0;
  oaq_pkg::oaq_axi_rsp_t rsp;
  oaq_pkg::oaq_pins_t pins;
  logic [15:0] sense_avg = 16'h0000;
  logic alert_out;
  logic alert_oe;
  logic irq;
  logic en = 1'b0;
  logic latch = 1'b0;
  logic [1:0] dly = 2'h0;
  logic [1:0] hysteresis_select = 2'h0;
  logic [31:0] lfsr = 32'hAADD;
  logic [31:0] rd;
  logic [1:0] resp;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int ph = 0;
  int m_lim = 1000;
  int m_hys = 20;
  int m_need = 1;
  int m_cnt = 0;
  int m_lwin = 0;
  bit m_over = 0;
  bit m_alert = 0;
  bit m_held = 0;

  oaq_top i_dut (.clk(clk), .sys_rst(sys_rst), .axi_req(req), .axi_rsp(rsp), .pins(pins),
    .sense_avg(sense_avg), .alert_out(alert_out), .alert_oe(alert_oe), .irq(irq));
  oaq_ctl_model i_ctl (.en(en), .latch(latch), .dly(dly), .hysteresis_select(hysteresis_select), .alert_out(alert_out),
    .alert_oe(alert_oe), .pins(pins));

  initial begin
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      error_cnt++;
      wrap_up();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic int over_v();
    lfsr = lfsr_next(lfsr);
    return m_lim + 1 + int'(lfsr[7:0]);
  endfunction

  function automatic int under_v();
    lfsr = lfsr_next(lfsr);
    return m_lim - m_hys - 1 - int'(lfsr[7:0]);
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s ended", name);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Sets the input for the coming window end, steps the model there, compares mid-window.
  task automatic win(input int s);
    int lo;
    sense_avg <= 16'(s);
    do @(posedge clk); while (cyc % 500 != ph);
    lo = (m_lim > m_hys) ? m_lim - m_hys : 0;
    // Latch raised mid-window while alerting holds the alert before this window ends.
    if (latch && m_alert) m_held = 1;
    m_over = m_over ? (s >= lo) : (s > m_lim);
    m_lwin = latch ? 0 : m_lwin + 1;
    m_cnt = m_over ? ((m_cnt < m_need) ? m_cnt + 1 : m_need) : 0;
    if (m_cnt == m_need) m_alert = 1;
    else if (!m_over && !m_held) m_alert = 0;
    if (latch && m_alert) m_held = 1;
    if (m_held && m_lwin >= 3 && !m_over) begin
      m_held = 0;
      m_alert = 0;
    end
    if (!en) begin
      m_over = 0;
      m_cnt = 0;
      m_alert = 0;
      m_held = 0;
    end
    chk(alert_oe, m_alert);
    chk(alert_out, 1'b0);
    chk(pins.alert_pin, !m_alert);
  endtask

  initial begin
    int t;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    axi_rd(oaq_pkg::ADDR_LIMIT, rd, resp);
    chk(rd, 32'h000003E8);
    axi_rd(oaq_pkg::ADDR_IRQ_MASK, rd, resp);
    chk(rd, 32'h00000000);
    axi_rd(8'h10, rd, resp);
    chk(resp, oaq_pkg::RESP_DECERR);
    lfsr = lfsr_next(lfsr);
    m_lim = 400 + int'(lfsr[8:0]);
    axi_wr(oaq_pkg::ADDR_LIMIT, 32'(m_lim), resp);
    chk(resp, oaq_pkg::RESP_OKAY);
    axi_wr(oaq_pkg::ADDR_IRQ_STAT, 32'h00000003, resp);
    en <= 1'b1;
    sense_avg <= 16'(m_lim + 1);
    for (t = 0; t < 2000 && alert_oe !== 1'b1; t++) @(posedge clk);
    chk(alert_oe, 1'b1);
    ph = (cyc + 250) % 500;
    while (cyc % 500 != ph) @(posedge clk);
    m_over = 1;
    m_cnt = 1;
    m_alert = 1;
    done("sync");
    for (int k = 0; k < 3; k++) begin
      win(0);
      dly <= 2'(k);
      m_need = (k == 0) ? 1 : (k == 1) ? 5 : 10;
      for (int i = 1; i < m_need; i++) win(over_v());
      win(under_v());
      for (int i = 0; i < m_need; i++) win(over_v());
      chk(alert_oe, 1'b1);
      done("delay");
    end
    for (int h = 0; h < 3; h++) begin
      win(0);
      hysteresis_select <= 2'(h);
      dly <= 2'h0;
      m_need = 1;
      m_hys = 20 << h;
      win(over_v());
      win(m_lim - m_hys);
      chk(alert_oe, 1'b1);
      win(m_lim - m_hys - 1);
      chk(alert_oe, 1'b0);
      done("hysteresis");
    end
    win(over_v());
    latch <= 1'b1;
    win(under_v());
    chk(alert_oe, 1'b1);
    win(under_v());
    latch <= 1'b0;
    win(under_v());
    win(under_v());
    chk(alert_oe, 1'b1);
    win(under_v());
    chk(alert_oe, 1'b0);
    done("latch");
    dly <= 2'h1;
    m_need = 5;
    repeat (4) win(over_v());
    en <= 1'b0;
    win(over_v());
    en <= 1'b1;
    repeat (4) win(over_v());
    chk(alert_oe, 1'b0);
    win(over_v());
    chk(alert_oe, 1'b1);
    done("disable");
    axi_wr(oaq_pkg::ADDR_IRQ_STAT, 32'h00000003, resp);
    axi_wr(oaq_pkg::ADDR_IRQ_MASK, 32'h00000003, resp);
    chk(irq, 1'b0);
    win(under_v());
    axi_rd(oaq_pkg::ADDR_IRQ_STAT, rd, resp);
    chk(rd, 32'h00000002);
    chk(irq, 1'b1);
    axi_wr(oaq_pkg::ADDR_IRQ_MASK, 32'h00000001, resp);
    axi_rd(oaq_pkg::ADDR_IRQ_MASK, rd, resp);
    chk(rd, 32'h00000001);
    chk(irq, 1'b0);
    axi_wr(oaq_pkg::ADDR_IRQ_STAT, 32'h00000002, resp);
    axi_rd(oaq_pkg::ADDR_IRQ_STAT, rd, resp);
    chk(rd, 32'h00000000);
    axi_rd(oaq_pkg::ADDR_STATE, rd, resp);
    // Enabled, pin released high, delay at ground, hysteresis at supply, nothing counted.
    chk(rd, 32'h00000928);
    done("interrupt");
    wrap_up();
  end
endmodule
`default_nettype wire
